// >>> smsp_pkg.sv
package smsp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] SMSP_IDX_CTRL = 8'h10;
    localparam logic [7:0] SMSP_IDX_STAT = 8'h11;
    localparam logic [7:0] SMSP_IDX_DATA = 8'h12;
    localparam int SMSP_AW = 12;
    localparam logic [11:0] SMSP_ADDR_CTRL = {2'h0, SMSP_IDX_CTRL, 2'h0};
    localparam logic [11:0] SMSP_ADDR_STAT = {2'h0, SMSP_IDX_STAT, 2'h0};
    localparam logic [11:0] SMSP_ADDR_DATA = {2'h0, SMSP_IDX_DATA, 2'h0};

    // Control register fields
    localparam int SMSP_CTL_RXIE = 7;
    localparam int SMSP_CTL_DMA = 6;
    localparam int SMSP_CTL_MSTR = 5;
    localparam int SMSP_CTL_CPOL = 4;
    localparam int SMSP_CTL_CLOCK_PHASE_SELECT = 3;
    localparam int SMSP_CTL_WOM = 2;
    localparam int SMSP_CTL_EN = 1;
    localparam int SMSP_CTL_TXIE = 0;

    // Status and control register fields
    localparam int SMSP_STS_RXF = 7;
    localparam int SMSP_STS_ERROR_INTERRUPT_ENABLE = 6;
    localparam int SMSP_STS_OVERRUN_FLAG = 5;
    localparam int SMSP_STS_MODE_FAULT_FLAG = 4;
    localparam int SMSP_STS_TXE = 3;
    localparam int SMSP_STS_MODE_FAULT_DETECT_ENABLE = 2;
    localparam int SMSP_STS_RATE_HI = 1;
    localparam int SMSP_STS_RATE_LO = 0;

    // Values after reset
    localparam logic SMSP_RST_MASTER = 1'b1;
    localparam logic SMSP_RST_CLOCK_PHASE_SELECT = 1'b1;
    localparam logic SMSP_RST_TXE = 1'b1;
    localparam logic [3:0] SMSP_SYNC_RST = 4'h8;

    // Rate divisor per rate code; half serial period is divisor cycles
    localparam logic [7:0] SMSP_RATE_DIVISOR [4] =
        '{8'h02, 8'h08, 8'h20, 8'h80};
    localparam logic [3:0] SMSP_LAST_EDGE = 4'hF;

    // Synchronised pin order
    localparam int SMSP_SYNC_W = 4;
    localparam int SMSP_PIN_SCK = 0;
    localparam int SMSP_PIN_MOSI = 1;
    localparam int SMSP_PIN_MISO = 2;
    localparam int SMSP_PIN_SS = 3;

    typedef enum logic {SMSP_PH_IDLE, SMSP_PH_SHIFT} smsp_phase_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } smsp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } smsp_apb_rsp_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } smsp_pin_in_t;

    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
    } smsp_pin_out_t;

    typedef struct packed {
        logic tx;
        logic rx;
        logic err;
    } smsp_irq_t;

    typedef struct packed {
        logic rx_ie;
        logic master;
        logic cpol;
        logic clock_phase_select;
        logic wom;
        logic en;
        logic tx_ie;
        logic error_interrupt_enable;
        logic mode_fault_detect_enable;
        logic [1:0] rate;
        logic rxf;
        logic overrun_flag;
        logic mode_fault_flag;
        logic txe;
        logic rxf_arm;
        logic overrun_flag_arm;
        logic mode_fault_flag_arm;
        logic [7:0] tx_data;
        logic tx_full;
        logic [7:0] rx_data;
        logic [7:0] shreg;
        logic out_bit;
        logic sck_r;
        logic sck_prev;
        logic slv_armed;
        logic [3:0] edge_cnt;
        smsp_phase_t phase;
        logic [31:0] prdata;
    } smsp_state_t;

    localparam smsp_state_t SMSP_ST_RST = '{
        master: SMSP_RST_MASTER,
        clock_phase_select: SMSP_RST_CLOCK_PHASE_SELECT,
        txe: SMSP_RST_TXE,
        phase: SMSP_PH_IDLE,
        default: '0
    };

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } smsp_div_state_t;

endpackage

// >>> smsp_sync.sv
`timescale 1ns/1ps
module smsp_sync
    import smsp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Pins in, synchronised levels out
    input wire logic [SMSP_SYNC_W-1:0] i_d,
    output logic [SMSP_SYNC_W-1:0] o_q
);

    logic [SMSP_SYNC_W-1:0] s1_r;
    logic [SMSP_SYNC_W-1:0] s2_r;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s1_r <= SMSP_SYNC_RST;
            s2_r <= SMSP_SYNC_RST;
        end
        else
        begin
            s1_r <= i_d;
            s2_r <= s1_r;
        end
    end

    assign o_q = s2_r;

endmodule

// >>> smsp_rate_div.sv
`timescale 1ns/1ps
module smsp_rate_div
    import smsp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_run,
    input wire logic [1:0] i_rate,
    // Half-period tick
    output logic o_tick
);

    smsp_div_state_t st_r;
    smsp_div_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!i_run)
        begin
            st_nxt.cnt = 8'h00;
        end
        else if (st_r.cnt == 8'(SMSP_RATE_DIVISOR[i_rate] - 8'h01))
        begin
            st_nxt.cnt = 8'h00;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = 8'(st_r.cnt + 8'h01);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_tick = st_r.tick;

endmodule

// >>> smsp_port.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Clock phase bit is read/write, picks clock/data timing, resets to one.
// - Wired-OR bit makes clock, MOSI and MISO open-drain; else push-pull.
// - Enable bit turns port on; clearing it partly resets; reset clears.
// - Transmit interrupt enable gates tx-empty requests; reset clears it.
// - Rx-full sets when a byte enters receive register; may interrupt.
// - Rx-full clears by status read showing it, then data read.
// - Error interrupt enable lets overrun and mode fault request interrupts.
// - Byte finished while rx-full still set: overrun, old byte kept.
// - Overrun clears by status read showing it, then data read.
// - Slave with detection on: select rising mid-transfer sets mode fault.
// - Master with detection on: select low at any time sets mode fault.
// - Mode fault clears by status read showing it, then control write.
// - Tx-empty sets when transmit byte moves to shifter; reset sets it.
// - Writing transmit data clears tx-empty.
// - Clearing detection enable keeps a set mode fault; setting allows it.
// - Master without detection ignores select level entirely.
// - Slave without detection only suppresses mode fault; select still works.
// - Rate code picks divisor 2, 8, 32, 128; master only; reset clears.
// - Data address writes transmit register, reads separate receive register.
// - Receive interrupt enable gates rx-full requests; reset clears it.
// - Deselected slave releases MISO and ignores clock, even mid-byte.
// - One byte is exchanged over exactly eight serial clock cycles.
module smsp_port
    import smsp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire smsp_apb_req_t i_apb,
    output smsp_apb_rsp_t o_apb,
    // Serial pins
    input wire smsp_pin_in_t i_pins,
    output smsp_pin_out_t o_pins,
    // Interrupt requests
    output smsp_irq_t o_irq
);

    smsp_state_t st_r;
    smsp_state_t st_nxt;

    logic [SMSP_SYNC_W-1:0] pin_sync;
    logic rate_tick;
    logic div_run;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;
    logic mst_on;
    logic slv_sel;
    logic setup;
    logic access;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_data;
    logic [7:0] ctrl_rd;
    logic [7:0] stat_rd;
    logic rx_clear;
    logic ov_clear;

    smsp_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d({i_pins.ss_n, i_pins.miso, i_pins.mosi, i_pins.sck}),
        .o_q(pin_sync)
    );

    smsp_rate_div u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(div_run),
        .i_rate(st_r.rate),
        .o_tick(rate_tick)
    );

    assign sck_s = pin_sync[SMSP_PIN_SCK];
    assign mosi_s = pin_sync[SMSP_PIN_MOSI];
    assign miso_s = pin_sync[SMSP_PIN_MISO];
    assign ss_s = pin_sync[SMSP_PIN_SS];

    assign mst_on = st_r.en & st_r.master;
    assign slv_sel = st_r.en & ~st_r.master & ~ss_s;
    // Rate field only runs the divider in master mode
    assign div_run = mst_on & (st_r.phase == SMSP_PH_SHIFT);

    assign setup = i_apb.psel & ~i_apb.penable;
    assign access = i_apb.psel & i_apb.penable;

    always_comb
    begin
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_data = 1'b0;
        if (i_apb.paddr == SMSP_ADDR_CTRL)
            hit_ctrl = 1'b1;
        else if (i_apb.paddr == SMSP_ADDR_STAT)
            hit_stat = 1'b1;
        else if (i_apb.paddr == SMSP_ADDR_DATA)
            hit_data = 1'b1;
    end

    always_comb
    begin
        ctrl_rd = 8'h00;
        ctrl_rd[SMSP_CTL_RXIE] = st_r.rx_ie;
        ctrl_rd[SMSP_CTL_DMA] = 1'b0;
        ctrl_rd[SMSP_CTL_MSTR] = st_r.master;
        ctrl_rd[SMSP_CTL_CPOL] = st_r.cpol;
        ctrl_rd[SMSP_CTL_CLOCK_PHASE_SELECT] = st_r.clock_phase_select;
        ctrl_rd[SMSP_CTL_WOM] = st_r.wom;
        ctrl_rd[SMSP_CTL_EN] = st_r.en;
        ctrl_rd[SMSP_CTL_TXIE] = st_r.tx_ie;
        stat_rd = 8'h00;
        stat_rd[SMSP_STS_RXF] = st_r.rxf;
        stat_rd[SMSP_STS_ERROR_INTERRUPT_ENABLE] = st_r.error_interrupt_enable;
        stat_rd[SMSP_STS_OVERRUN_FLAG] = st_r.overrun_flag;
        stat_rd[SMSP_STS_MODE_FAULT_FLAG] = st_r.mode_fault_flag;
        stat_rd[SMSP_STS_TXE] = st_r.txe;
        stat_rd[SMSP_STS_MODE_FAULT_DETECT_ENABLE] = st_r.mode_fault_detect_enable;
        stat_rd[SMSP_STS_RATE_HI] = st_r.rate[1];
        stat_rd[SMSP_STS_RATE_LO] = st_r.rate[0];
    end

    // Second step of the two-step clears: a data read after an armed status
    assign rx_clear = access & ~i_apb.pwrite & hit_data & st_r.rxf_arm;
    assign ov_clear = access & ~i_apb.pwrite & hit_data & st_r.overrun_flag_arm;

    always_comb
    begin
        logic lead;
        logic trail;
        logic capture;
        logic launch;
        logic done;
        logic in_bit;
        logic load;
        logic rxf_set;
        logic overrun_flag_set;
        logic txe_set;
        logic mode_fault_flag_set;
        logic mode_fault_flag_clr;
        lead = 1'b0;
        trail = 1'b0;
        capture = 1'b0;
        launch = 1'b0;
        done = 1'b0;
        load = 1'b0;
        rxf_set = 1'b0;
        overrun_flag_set = 1'b0;
        txe_set = 1'b0;
        mode_fault_flag_set = 1'b0;
        mode_fault_flag_clr = 1'b0;
        in_bit = st_r.master ? miso_s : mosi_s;
        st_nxt = st_r;

        // Read data is latched in setup so the access edge sees stable data
        if (setup && !i_apb.pwrite)
        begin
            if (hit_ctrl)
                st_nxt.prdata = {24'h000000, ctrl_rd};
            else if (hit_stat)
                st_nxt.prdata = {24'h000000, stat_rd};
            else if (hit_data)
                st_nxt.prdata = {24'h000000, st_r.rx_data};
            else
                st_nxt.prdata = 32'h00000000;
        end

        // Mode fault detection; master without detection ignores select
        if (st_r.en && st_r.mode_fault_detect_enable)
        begin
            if (st_r.master && !ss_s)
                mode_fault_flag_set = 1'b1;
            else if (!st_r.master && ss_s
                     && st_r.phase == SMSP_PH_SHIFT)
                mode_fault_flag_set = 1'b1;
        end

        st_nxt.sck_prev = sck_s;
        if (ss_s)
            st_nxt.slv_armed = 1'b1;

        if (!st_r.en)
        begin
            // Partial reset: engine idle, transmit side emptied
            st_nxt.phase = SMSP_PH_IDLE;
            st_nxt.edge_cnt = 4'h0;
            st_nxt.sck_r = st_r.cpol;
            st_nxt.tx_full = 1'b0;
            txe_set = 1'b1;
        end
        else
        begin
            case (st_r.phase)
                SMSP_PH_IDLE:
                begin
                    st_nxt.sck_r = st_r.cpol;
                    st_nxt.edge_cnt = 4'h0;
                    if (st_r.master)
                    begin
                        load = st_r.tx_full;
                    end
                    // Phase zero slave waits for select to toggle
                    else if (slv_sel && (st_r.clock_phase_select || st_r.slv_armed))
                    begin
                        load = 1'b1;
                        st_nxt.slv_armed = 1'b0;
                    end
                end
                SMSP_PH_SHIFT:
                begin
                    if (st_r.master)
                    begin
                        if (rate_tick)
                        begin
                            st_nxt.sck_r = ~st_r.sck_r;
                            lead = (st_r.sck_r == st_r.cpol);
                            trail = ~lead;
                        end
                    end
                    else if (ss_s)
                    begin
                        // Deselect aborts the byte in flight
                        st_nxt.phase = SMSP_PH_IDLE;
                        st_nxt.edge_cnt = 4'h0;
                    end
                    else if (sck_s != st_r.sck_prev)
                    begin
                        lead = (st_r.sck_prev == st_r.cpol);
                        trail = ~lead;
                    end
                    // Phase one launches on leading, samples on trailing
                    capture = st_r.clock_phase_select ? trail : lead;
                    launch = st_r.clock_phase_select ? lead : trail;
                    if (capture)
                        st_nxt.shreg = {st_r.shreg[6:0], in_bit};
                    if (launch)
                        st_nxt.out_bit = st_r.shreg[7];
                    if (lead || trail)
                    begin
                        st_nxt.edge_cnt = 4'(st_r.edge_cnt + 4'h1);
                        if (st_r.edge_cnt == SMSP_LAST_EDGE)
                        begin
                            done = 1'b1;
                            st_nxt.phase = SMSP_PH_IDLE;
                            st_nxt.edge_cnt = 4'h0;
                        end
                    end
                end
                default:
                begin
                    st_nxt.phase = SMSP_PH_IDLE;
                end
            endcase
        end

        if (load)
        begin
            st_nxt.shreg = st_r.tx_data;
            st_nxt.out_bit = st_r.tx_data[7];
            st_nxt.phase = SMSP_PH_SHIFT;
            st_nxt.edge_cnt = 4'h0;
            if (st_r.tx_full)
            begin
                st_nxt.tx_full = 1'b0;
                txe_set = 1'b1;
            end
        end

        // A byte completed while unread is lost; same-cycle read frees room
        if (done)
        begin
            if (st_r.rxf && !rx_clear)
            begin
                overrun_flag_set = 1'b1;
            end
            else
            begin
                st_nxt.rx_data = st_nxt.shreg;
                rxf_set = 1'b1;
            end
        end

        if (access)
        begin
            if (i_apb.pwrite)
            begin
                if (hit_ctrl)
                begin
                    st_nxt.rx_ie = i_apb.pwdata[SMSP_CTL_RXIE];
                    st_nxt.master = i_apb.pwdata[SMSP_CTL_MSTR];
                    st_nxt.cpol = i_apb.pwdata[SMSP_CTL_CPOL];
                    st_nxt.clock_phase_select = i_apb.pwdata[SMSP_CTL_CLOCK_PHASE_SELECT];
                    st_nxt.wom = i_apb.pwdata[SMSP_CTL_WOM];
                    st_nxt.en = i_apb.pwdata[SMSP_CTL_EN];
                    st_nxt.tx_ie = i_apb.pwdata[SMSP_CTL_TXIE];
                    mode_fault_flag_clr = st_r.mode_fault_flag_arm;
                    st_nxt.mode_fault_flag_arm = 1'b0;
                end
                else if (hit_stat)
                begin
                    st_nxt.error_interrupt_enable = i_apb.pwdata[SMSP_STS_ERROR_INTERRUPT_ENABLE];
                    st_nxt.mode_fault_detect_enable = i_apb.pwdata[SMSP_STS_MODE_FAULT_DETECT_ENABLE];
                    st_nxt.rate[1] = i_apb.pwdata[SMSP_STS_RATE_HI];
                    st_nxt.rate[0] = i_apb.pwdata[SMSP_STS_RATE_LO];
                end
                else if (hit_data)
                begin
                    // Writes go only to transmit side
                    st_nxt.tx_data = i_apb.pwdata[7:0];
                    st_nxt.tx_full = 1'b1;
                    st_nxt.txe = 1'b0;
                    txe_set = 1'b0;
                end
            end
            else
            begin
                if (hit_stat)
                begin
                    // Arm from what software actually saw
                    st_nxt.rxf_arm = st_r.prdata[SMSP_STS_RXF];
                    st_nxt.overrun_flag_arm = st_r.prdata[SMSP_STS_OVERRUN_FLAG];
                    st_nxt.mode_fault_flag_arm = st_r.prdata[SMSP_STS_MODE_FAULT_FLAG];
                end
                else if (hit_data)
                begin
                    st_nxt.rxf_arm = 1'b0;
                    st_nxt.overrun_flag_arm = 1'b0;
                end
            end
        end

        // Hardware set wins over software clear, except that a data write clears tx-empty
        st_nxt.rxf = (st_r.rxf & ~rx_clear) | rxf_set;
        st_nxt.overrun_flag = (st_r.overrun_flag & ~ov_clear) | overrun_flag_set;
        st_nxt.mode_fault_flag = (st_r.mode_fault_flag & ~mode_fault_flag_clr) | mode_fault_flag_set;
        if (txe_set)
            st_nxt.txe = 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            st_r <= SMSP_ST_RST;
        else
            st_r <= st_nxt;
    end

    // Zero wait states; read data already latched during setup
    assign o_apb.prdata = st_r.prdata;
    assign o_apb.pready = 1'b1;
    assign o_apb.pslverr = access & ~(hit_ctrl | hit_stat | hit_data);

    // Open-drain drives only lows, so a high level needs the pullup
    assign o_pins.sck = st_r.sck_r;
    assign o_pins.sck_oe_n = ~(mst_on & (~st_r.wom | ~st_r.sck_r));
    assign o_pins.mosi = st_r.out_bit;
    assign o_pins.mosi_oe_n = ~(mst_on & (~st_r.wom | ~st_r.out_bit));
    assign o_pins.miso = st_r.out_bit;
    assign o_pins.miso_oe_n = ~(slv_sel & (~st_r.wom | ~st_r.out_bit));

    assign o_irq.tx = st_r.txe & st_r.tx_ie;
    assign o_irq.rx = st_r.rxf & st_r.rx_ie;
    assign o_irq.err = st_r.error_interrupt_enable & (st_r.overrun_flag | st_r.mode_fault_flag);

endmodule

// >>> smsp_chk.sv
`timescale 1ns/1ps
module smsp_chk
    import smsp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Bus
    input wire smsp_apb_req_t i_apb,
    input wire smsp_apb_rsp_t o_apb,
    // Pins and requests
    input wire smsp_pin_in_t i_pins,
    input wire smsp_pin_out_t o_pins,
    input wire smsp_irq_t o_irq
);
    logic [7:0] ctl_r;
    logic [7:0] sts_r;
    logic acc;
    logic wr;
    logic mapped;
    assign acc = i_apb.psel && i_apb.penable;
    assign wr = acc && i_apb.pwrite;
    assign mapped = i_apb.paddr inside
        {SMSP_ADDR_CTRL, SMSP_ADDR_STAT, SMSP_ADDR_DATA};
    // Shadows of what software wrote, updated on the same edge as the port
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ctl_r <= 8'h28;
            sts_r <= 8'h08;
        end
        else
        begin
            if (wr && i_apb.paddr == SMSP_ADDR_CTRL)
                ctl_r <= i_apb.pwdata[7:0];
            if (wr && i_apb.paddr == SMSP_ADDR_STAT)
                sts_r <= i_apb.pwdata[7:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_dwrite;
        wr && i_apb.paddr == SMSP_ADDR_DATA && ctl_r[SMSP_CTL_EN];
    endsequence
    property p_slverr;
        acc |-> o_apb.pready && (o_apb.pslverr == !mapped);
    endproperty
    property p_txe_clr;
        s_dwrite ##0 ctl_r[SMSP_CTL_TXIE] |=> !o_irq.tx;
    endproperty
    property p_txie;
        !ctl_r[SMSP_CTL_TXIE] |-> !o_irq.tx;
    endproperty
    property p_rxie;
        !ctl_r[SMSP_CTL_RXIE] |-> !o_irq.rx;
    endproperty
    property p_error_interrupt_enable;
        !sts_r[SMSP_STS_ERROR_INTERRUPT_ENABLE] |-> !o_irq.err;
    endproperty
    property p_off;
        !ctl_r[SMSP_CTL_EN] |->
            o_pins.sck_oe_n && o_pins.mosi_oe_n && o_pins.miso_oe_n;
    endproperty
    property p_wom;
        ctl_r[SMSP_CTL_WOM] |-> (o_pins.sck_oe_n || !o_pins.sck)
            && (o_pins.mosi_oe_n || !o_pins.mosi);
    endproperty
    property p_mst_miso;
        ctl_r[SMSP_CTL_EN] && ctl_r[SMSP_CTL_MSTR] |-> o_pins.miso_oe_n;
    endproperty
    property p_rate;
        $changed(o_pins.sck) && sts_r[1:0] == 2'h1 && ctl_r[SMSP_CTL_MSTR]
            |=> $stable(o_pins.sck)[*7];
    endproperty
    // Two synchroniser stages, then the output enable follows
    property p_desel;
        i_pins.ss_n [*3] |-> o_pins.miso_oe_n;
    endproperty
    a_slverr: assert property (p_slverr) else $error("bus response wrong");
    a_txe_clr: assert property (p_txe_clr) else $error("tx empty kept");
    a_txie: assert property (p_txie) else $error("tx request ungated");
    a_rxie: assert property (p_rxie) else $error("rx request ungated");
    a_error_interrupt_enable: assert property (p_error_interrupt_enable) else $error("err request ungated");
    a_off: assert property (p_off) else $error("disabled port drives");
    a_wom: assert property (p_wom) else $error("open drain drives high");
    a_mst_miso: assert property (p_mst_miso)
        else $error("master drives miso");
    a_desel: assert property (p_desel) else $error("miso driven");
    a_rate: assert property (p_rate) else $error("half period not 8");
endmodule
bind smsp_port smsp_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_apb(i_apb), .o_apb(o_apb), .i_pins(i_pins), .o_pins(o_pins),
    .o_irq(o_irq));

// >>> smsp_peer.sv
`timescale 1ns/1ps
module smsp_peer
(
    // Serial side
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_sel_n,
    output logic o_miso,
    // Bench side
    input wire logic [7:0] i_tx,
    output logic [7:0] o_rx
);
    logic [2:0] cnt = 3'h0;
    logic bit_r = 1'b0;
    // Released line shows the inverse so a stale bit is never trusted
    assign o_miso = i_sel_n ? ~bit_r : bit_r;
    initial
    begin
        o_rx = 8'h00;
    end
    // Change on leading edge, sample on trailing edge
    always @(posedge i_sck)
    begin
        if (!i_sel_n)
            bit_r <= i_tx[3'h7 - cnt];
    end
    always @(negedge i_sck)
    begin
        if (!i_sel_n)
        begin
            o_rx <= {o_rx[6:0], i_mosi};
            cnt <= cnt + 3'h1;
        end
    end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb
    import smsp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n;
    smsp_apb_req_t req;
    smsp_apb_rsp_t rsp;
    smsp_pin_in_t pin_i;
    smsp_pin_out_t pin_o;
    smsp_irq_t irq;
    logic ss_n, sel_n, miso_p, sck_w, mosi_w, slverr;
    logic ext_sck, ext_mosi;
    logic [7:0] ptx, prx, q, sq;
    int errors, samples_checked;
    always #2 clk = ~clk;
    // Released pins show the pullup unless the bench drives them as master
    assign sck_w = pin_o.sck_oe_n ? ext_sck : pin_o.sck;
    assign mosi_w = pin_o.mosi_oe_n ? ext_mosi : pin_o.mosi;
    assign pin_i = {sck_w, mosi_w,
        pin_o.miso_oe_n ? miso_p : pin_o.miso, ss_n};
    smsp_port dut (.i_clk(clk), .i_rst_n(rst_n), .i_apb(req), .o_apb(rsp),
        .i_pins(pin_i), .o_pins(pin_o), .o_irq(irq));
    smsp_peer peer (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(sel_n),
        .o_miso(miso_p), .i_tx(ptx), .o_rx(prx));
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
            @(posedge clk);
        while (rsp.pready !== 1'b1);
        q = rsp.prdata[7:0];
        slverr = rsp.pslverr;
        req <= '0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e, input string n);
        apb(1'b0, a, 8'h00);
        chk(n, q, e);
    endtask
    task wait_sts(input int b);
        q = 8'h00;
        for (int i = 0; i < 200 && q[b] !== 1'b1; i++)
            apb(1'b0, SMSP_ADDR_STAT, 8'h00);
    endtask
    // Bench as phase zero master: data set up and slave bit read before lead
    task slv_bits(input logic [7:0] d, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            @(posedge clk);
            ext_mosi <= d[i];
            repeat (8) @(posedge clk);
            sq[i] = pin_i.miso;
            ext_sck <= 1'b1;
            repeat (8) @(posedge clk);
            ext_sck <= 1'b0;
        end
        // Let the synchronised last edge reach the flags
        repeat (4) @(posedge clk);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report;
    end
    initial
    begin
        errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        req = '0;
        ss_n = 1'b1;
        sel_n = 1'b1;
        ptx = 8'h00;
        ext_sck = 1'b1;
        ext_mosi = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(SMSP_ADDR_CTRL, 8'h28, "ctrl reset");
        rd(SMSP_ADDR_STAT, 8'h08, "status reset");
        chk("irq reset", {5'h0, irq}, 8'h00);
        rd(12'h000, 8'h00, "unmapped read");
        chk("unmapped err", {7'h0, slverr}, 8'h01);
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b1, SMSP_ADDR_STAT, 8'(r));
            rd(SMSP_ADDR_STAT, 8'h08 | 8'(r), "rate field");
        end
        apb(1'b1, SMSP_ADDR_CTRL, 8'h2B);
        apb(1'b1, SMSP_ADDR_STAT, 8'h41);
        @(negedge clk);
        chk("tx irq", {7'h0, irq.tx}, 8'h01);
        sel_n <= 1'b0;
        ptx <= 8'h3C;
        apb(1'b1, SMSP_ADDR_DATA, 8'hA5);
        wait_sts(SMSP_STS_RXF);
        chk("peer rx", prx, 8'hA5);
        chk("status rxf", q, 8'hC9);
        rd(SMSP_ADDR_DATA, 8'h3C, "rx byte");
        rd(SMSP_ADDR_STAT, 8'h49, "rxf cleared");
        // Select held low with detection off must not disturb the master
        ss_n <= 1'b0;
        apb(1'b1, SMSP_ADDR_CTRL, 8'hAE);
        ptx <= 8'hC3;
        apb(1'b1, SMSP_ADDR_DATA, 8'h5A);
        wait_sts(SMSP_STS_RXF);
        @(negedge clk);
        chk("rx irq", {7'h0, irq.rx}, 8'h01);
        ptx <= 8'h66;
        apb(1'b1, SMSP_ADDR_DATA, 8'h0F);
        wait_sts(SMSP_STS_OVERRUN_FLAG);
        chk("peer rx 2", prx, 8'h0F);
        chk("overrun_flag status", q, 8'hE9);
        @(negedge clk);
        chk("err irq", {7'h0, irq.err}, 8'h01);
        rd(SMSP_ADDR_DATA, 8'hC3, "old byte kept");
        rd(SMSP_ADDR_STAT, 8'h49, "overrun_flag cleared");
        apb(1'b1, SMSP_ADDR_STAT, 8'h45);
        repeat (6) @(posedge clk);
        ss_n <= 1'b1;
        rd(SMSP_ADDR_STAT, 8'h5D, "mode_fault_flag set");
        apb(1'b1, SMSP_ADDR_STAT, 8'h41);
        rd(SMSP_ADDR_STAT, 8'h59, "mode_fault_flag kept");
        apb(1'b1, SMSP_ADDR_CTRL, 8'hAE);
        rd(SMSP_ADDR_STAT, 8'h49, "mode_fault_flag cleared");
        // Slave, phase zero, detection off; peer deselected
        sel_n <= 1'b1;
        ext_sck <= 1'b0;
        apb(1'b1, SMSP_ADDR_CTRL, 8'h02);
        apb(1'b1, SMSP_ADDR_DATA, 8'h96);
        ss_n <= 1'b0;
        slv_bits(8'h3A, 8);
        chk("slave tx", sq, 8'h96);
        rd(SMSP_ADDR_STAT, 8'hC9, "slave rxf");
        rd(SMSP_ADDR_DATA, 8'h3A, "slave rx");
        ss_n <= 1'b1;
        apb(1'b1, SMSP_ADDR_STAT, 8'h45);
        ss_n <= 1'b0;
        // Deselect halfway through a byte with detection on
        slv_bits(8'hF0, 4);
        ss_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(SMSP_ADDR_STAT, 8'h5D, "slave mode_fault_flag");
        chk("miso released", {7'h0, pin_o.miso_oe_n}, 8'h01);
        final_report;
    end
endmodule
